//--- src/ttc_pkg.sv
// Notes on behaviour
// - Count is one 16-bit value, seen by software as high and low bytes.
// - Select bit picks internal clock path (timer) or count pin (counter).
// - Count advances only while run is set; clearing run halts it.
// - Prescale bit picks undivided system clock or system clock divided by 12.
// - Mode from clock-output enable, select, capture/reload select and up/down enable bits.
// - With run clear the count stops, but trigger edge detection stays active.
// - Capture mode, trigger disabled: count and set overflow flag on overflow.
// - Capture mode, trigger enabled: falling trigger edge copies count, sets event flag.
// - Up/down enable resets to 0, so reload mode counts up by default.
// - Reload mode counting up: at 0xFFFF set overflow flag and load reload value.
// - Reload mode, trigger enabled: falling trigger edge also reloads, sets event flag.
// - Up/down enabled: trigger level sets direction; trigger enable is ignored.
// - Up/down, trigger high: count up, overflow at 0xFFFF reloads, sets flag.
// - Up/down, trigger low: count down; at reload value load 0xFFFF, set flag.
// - Up/down: event flag toggles on each wrap, a 17th bit, no interrupt.
// - Clock-output: count pin gives 50% clock, fsys / (4 x (65536 - reload)).
// - Clock-output: overflow requests no interrupt.
// - Overflow and event flags share one timer interrupt request.
// - Flags set by hardware, writable by software; software, reset or the up/down event-flag toggle clears.
// - Global and timer enables both set: either flag raises the interrupt, the event flag only outside up/down.
// - Prescale encoding: 0 is system clock / 12, 1 is system clock.
// - Select encoding: 0 timer, pin is I/O; 1 counter with pin pull-up on.
// - Clock-output enable: 0 pin is input or I/O, 1 pin drives clock unless select is 1.
package ttc_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] RELOAD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Clock division
  // ----------------------------------------------------------------
  localparam int unsigned PRESCALE_DIV = 12;
  localparam int unsigned PRESC_W = 4;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE_DIV - 1);
  localparam logic [PRESC_W-1:0] PRESC_RST = 4'h0;
  // Clock-output mode counts every second system clock, giving the factor 4
  localparam int unsigned CLKOUT_STEP_DIV = 2;
  localparam logic CLKOUT_STEP_LAST = 1'(CLKOUT_STEP_DIV - 1);

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_UPDOWN,
    MODE_CLKOUT
  } ttc_mode_e;

endpackage : ttc_pkg

//--- src/ttc_pin_sampler.sv
module ttc_pin_sampler (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Pin
  input wire logic i_pin,
  // Sampled level and edge
  output logic o_level,
  output logic o_fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } ttc_samp_s;

  ttc_samp_s st_q;
  ttc_samp_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.meta = i_pin;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  // Idle level of both pins is high, so reset to 1 avoids a false edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.sync;
  assign o_fall = st_q.prev & ~st_q.sync;

endmodule // ttc_pin_sampler

//--- src/ttc_timer.sv
module ttc_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,

  // Control bits
  input wire logic i_run_control,
  input wire logic i_timer_counter_select,
  input wire logic i_capture_reload_select,
  input wire logic i_external_trigger_enable,
  input wire logic i_prescale_select,
  input wire logic i_clock_output_enable,
  input wire logic i_up_down_enable,
  input wire logic i_global_irq_enable,
  input wire logic i_timer_irq_enable,

  // Software byte writes
  input wire logic [ttc_pkg::BYTE_W-1:0] i_wdata,
  input wire logic i_count_high_byte_wr,
  input wire logic i_count_low_byte_wr,
  input wire logic i_capture_reload_high_byte_wr,
  input wire logic i_capture_reload_low_byte_wr,

  // Software flag write
  input wire logic i_flags_wr,
  input wire logic i_overflow_flag_wdata,
  input wire logic i_external_event_flag_wdata,

  // External pins
  input wire logic i_count_input_pin,
  input wire logic i_trigger_pin,
  output logic o_count_input_pin_o,
  output logic o_count_input_pin_oe,
  output logic o_count_input_pin_pullup,

  // Register read-back
  output logic [ttc_pkg::BYTE_W-1:0] o_count_high_byte,
  output logic [ttc_pkg::BYTE_W-1:0] o_count_low_byte,
  output logic [ttc_pkg::BYTE_W-1:0] o_capture_reload_high_byte,
  output logic [ttc_pkg::BYTE_W-1:0] o_capture_reload_low_byte,
  output logic o_overflow_flag,
  output logic o_external_event_flag,

  // Interrupt request
  output logic o_timer_irq
);

  import ttc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] reload;
    logic ovf_flag;
    logic evt_flag;
    logic [PRESC_W-1:0] presc;
    logic clkout_phase;
    logic clk_pin;
  } ttc_state_s;

  ttc_state_s st_q;
  ttc_state_s st_d;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Both pins pass through the same sampler so their delays match
  logic cnt_pin_level;
  logic cnt_pin_fall;
  logic trig_level;
  logic trig_fall;

  ttc_pin_sampler u_count_pin (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_count_input_pin),
    .o_level(cnt_pin_level),
    .o_fall(cnt_pin_fall)
  );

  ttc_pin_sampler u_trigger_pin (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_trigger_pin),
    .o_level(trig_level),
    .o_fall(trig_fall)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  ttc_mode_e mode;

  // Mode select
  // Count pin as source together with clock output is not a supported mix; it
  // decodes as one of the counting modes and the pin stays an input
  always_comb begin
    if (i_clock_output_enable & ~i_timer_counter_select) begin
      mode = MODE_CLKOUT;
    end else if (i_capture_reload_select) begin
      mode = MODE_CAPTURE;
    end else if (i_up_down_enable) begin
      mode = MODE_UPDOWN;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  // ----------------------------------------------------------------
  // Count step
  // ----------------------------------------------------------------
  logic presc_wrap;
  logic clkout_step;
  logic step;

  // Divide by 12 when prescale bit is 0
  // Prescaler runs from zero to its last value; one step per wrap
  assign presc_wrap = (st_q.presc == PRESC_LAST);

  assign clkout_step = (st_q.clkout_phase == CLKOUT_STEP_LAST);

  // Pin edges already carry the synchroniser delay; the prescaler does not apply to them
  // Source select gated by run
  always_comb begin
    step = 1'b0;
    if (i_run_control) begin
      if (mode == MODE_CLKOUT) begin
        step = clkout_step;
      end else if (i_timer_counter_select) begin
        step = cnt_pin_fall;
      end else if (i_prescale_select) begin
        step = 1'b1;
      end else begin
        step = presc_wrap;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic at_max;
  logic at_reload;
  logic count_up;
  logic wrap;
  logic trig_event;
  logic ovf_set;
  logic evt_set;
  logic evt_toggle;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] reload_next;

  assign at_max = (st_q.count == COUNT_MAX);
  // Down count ends where the reload value sits
  assign at_reload = (st_q.count == st_q.reload);
  assign count_up = (mode != MODE_UPDOWN) | trig_level;
  assign wrap = step & (count_up ? at_max : at_reload);
  // Edges arrive about three clocks after the pin falls
  // Trigger edges are seen while stopped, ignored in up/down
  assign trig_event = trig_fall & i_external_trigger_enable & (mode != MODE_UPDOWN);

  always_comb begin
    count_next = st_q.count;
    reload_next = st_q.reload;
    ovf_set = 1'b0;
    evt_set = 1'b0;
    evt_toggle = 1'b0;

    unique case (mode)
      MODE_CAPTURE: begin
        if (step) begin
          count_next = st_q.count + 16'h0001;
          ovf_set = at_max;
        end
        // Capture on edge
        // The copy takes the count as it stood before this edge's step
        if (trig_event) begin
          reload_next = st_q.count;
          evt_set = 1'b1;
        end
      end
      MODE_RELOAD: begin
        if (step) begin
          count_next = at_max ? st_q.reload : st_q.count + 16'h0001;
          ovf_set = at_max;
        end
        if (trig_event) begin
          count_next = st_q.reload;
          evt_set = 1'b1;
        end
      end
      MODE_UPDOWN: begin
        if (step) begin
          if (count_up) begin
            count_next = at_max ? st_q.reload : st_q.count + 16'h0001;
          end else begin
            count_next = at_reload ? COUNT_MAX : st_q.count - 16'h0001;
          end
          ovf_set = wrap;
          evt_toggle = wrap;
        end
      end
      MODE_CLKOUT: begin
        // Reload on overflow; no overflow flag here
        if (step) begin
          count_next = at_max ? st_q.reload : st_q.count + 16'h0001;
        end
        // Overflow stays silent so the rate can be shared with another user
        ovf_set = 1'b0;
        if (trig_event) begin
          count_next = st_q.reload;
          evt_set = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Prescaler runs only while run is set with prescale and select bits 0, clock-output mode included; restarts otherwise
    if (i_run_control & ~i_prescale_select & ~i_timer_counter_select) begin
      st_d.presc = presc_wrap ? PRESC_RST : st_q.presc + 4'h1;
    end else begin
      st_d.presc = PRESC_RST;
    end

    // Phase restarts while stopped, so a start always waits two clocks for its step
    if (i_run_control & (mode == MODE_CLKOUT)) begin
      st_d.clkout_phase = ~st_q.clkout_phase;
    end else begin
      st_d.clkout_phase = 1'b0;
    end

    // Byte writes override the step for the byte written
    // A carry into the other byte can be lost, so software should stop the count first
    st_d.count = count_next;
    if (i_count_high_byte_wr) begin
      st_d.count[COUNT_W-1:BYTE_W] = i_wdata;
    end
    if (i_count_low_byte_wr) begin
      st_d.count[BYTE_W-1:0] = i_wdata;
    end

    st_d.reload = reload_next;
    if (i_capture_reload_high_byte_wr) begin
      st_d.reload[COUNT_W-1:BYTE_W] = i_wdata;
    end
    if (i_capture_reload_low_byte_wr) begin
      st_d.reload[BYTE_W-1:0] = i_wdata;
    end

    // Software writes either value; a hardware set wins over a clear
    // Hardware sets come last so an event beside a clearing write is kept
    if (i_flags_wr) begin
      st_d.ovf_flag = i_overflow_flag_wdata;
      st_d.evt_flag = i_external_event_flag_wdata;
    end
    if (ovf_set) begin
      st_d.ovf_flag = 1'b1;
    end
    if (evt_set) begin
      st_d.evt_flag = 1'b1;
    end
    // Toggle is taken from the stored value, ignoring a same-cycle write
    if (evt_toggle) begin
      st_d.evt_flag = ~st_q.evt_flag;
    end

    // Half period per overflow gives 50% duty
    if (mode == MODE_CLKOUT) begin
      if (step & at_max) begin
        st_d.clk_pin = ~st_q.clk_pin;
      end
    end else begin
      st_d.clk_pin = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= '{
        count: COUNT_RST,
        reload: RELOAD_RST,
        ovf_flag: 1'b0,
        evt_flag: 1'b0,
        presc: PRESC_RST,
        clkout_phase: 1'b0,
        clk_pin: 1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_count_high_byte = st_q.count[COUNT_W-1:BYTE_W];
  assign o_count_low_byte = st_q.count[BYTE_W-1:0];
  assign o_capture_reload_high_byte = st_q.reload[COUNT_W-1:BYTE_W];
  assign o_capture_reload_low_byte = st_q.reload[BYTE_W-1:0];
  assign o_overflow_flag = st_q.ovf_flag;
  assign o_external_event_flag = st_q.evt_flag;

  // ----------------------------------------------------------------
  // Count pin
  // ----------------------------------------------------------------
  // Pin drives clock only in clock-output mode
  assign o_count_input_pin_o = st_q.clk_pin;
  assign o_count_input_pin_oe = (mode == MODE_CLKOUT);
  assign o_count_input_pin_pullup = i_timer_counter_select;

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  logic irq_enabled;
  logic evt_irq_cause;
  logic irq_cause;

  assign irq_enabled = i_global_irq_enable & i_timer_irq_enable;
  // The event flag is a count bit in up/down mode, so it is masked there
  assign evt_irq_cause = st_q.evt_flag & (mode != MODE_UPDOWN);
  // Overflow flag, or event flag outside up/down, even one set by software, asks for the shared vector
  assign irq_cause = st_q.ovf_flag | evt_irq_cause;
  // Clock-output overflow never sets the flag, so it cannot reach here
  assign o_timer_irq = irq_enabled & irq_cause;

endmodule // ttc_timer

//--- tb/ttc_timer_sva.sv
module ttc_timer_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Control bits
  input wire logic i_run_control,
  input wire logic i_timer_counter_select,
  input wire logic i_capture_reload_select,
  input wire logic i_external_trigger_enable,
  input wire logic i_prescale_select,
  input wire logic i_clock_output_enable,
  input wire logic i_up_down_enable,
  input wire logic i_global_irq_enable,
  input wire logic i_timer_irq_enable,
  // Writes
  input wire logic i_count_high_byte_wr,
  input wire logic i_count_low_byte_wr,
  input wire logic i_flags_wr,
  // Outputs
  input wire logic o_count_input_pin_pullup,
  input wire logic [ttc_pkg::BYTE_W-1:0] o_count_high_byte,
  input wire logic [ttc_pkg::BYTE_W-1:0] o_count_low_byte,
  input wire logic [ttc_pkg::BYTE_W-1:0] o_capture_reload_high_byte,
  input wire logic [ttc_pkg::BYTE_W-1:0] o_capture_reload_low_byte,
  input wire logic o_overflow_flag,
  input wire logic o_external_event_flag,
  input wire logic o_timer_irq
);
  import ttc_pkg::*;
  logic [COUNT_W-1:0] cnt;
  logic [COUNT_W-1:0] rl;
  logic tmr;
  logic clk_mode;
  assign cnt = {o_count_high_byte, o_count_low_byte};
  assign rl = {o_capture_reload_high_byte, o_capture_reload_low_byte};
  // Undivided timer with no byte write competing for the count
  assign tmr = i_run_control & i_prescale_select & ~i_timer_counter_select & ~i_clock_output_enable
    & ~i_count_high_byte_wr & ~i_count_low_byte_wr;
  assign clk_mode = i_run_control & i_clock_output_enable & ~i_timer_counter_select;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_pullup; o_count_input_pin_pullup == i_timer_counter_select; endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");
  property p_irq_gate; o_timer_irq |-> i_global_irq_enable && i_timer_irq_enable
    && (o_overflow_flag || o_external_event_flag); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");
  property p_irq_ovf; i_global_irq_enable && i_timer_irq_enable && o_overflow_flag |-> o_timer_irq; endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("irq missing");
  property p_hold; !i_run_control && !i_count_high_byte_wr && !i_count_low_byte_wr
    && !i_external_trigger_enable |=> $stable(cnt); endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");
  property p_sticky; o_overflow_flag && !i_flags_wr |=> o_overflow_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_step; tmr && i_capture_reload_select && cnt != COUNT_MAX |=> cnt == $past(cnt) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("no step");
  property p_cap_wrap; tmr && i_capture_reload_select && cnt == COUNT_MAX |=> cnt == COUNT_RST && o_overflow_flag;
  endproperty
  a_cap_wrap: assert property (p_cap_wrap) else $error("capture wrap wrong");
  property p_reload; tmr && !i_capture_reload_select && !i_up_down_enable && cnt == COUNT_MAX
    |=> cnt == $past(rl) && o_overflow_flag; endproperty
  a_reload: assert property (p_reload) else $error("reload wrong");
  property p_clk_noflag; clk_mode && !i_flags_wr ##1 clk_mode && !i_flags_wr && !o_overflow_flag
    |=> !o_overflow_flag; endproperty
  a_clk_noflag: assert property (p_clk_noflag) else $error("flag in clock-out");
endmodule // ttc_timer_sva

bind ttc_timer ttc_timer_sva u_sva (.i_clk(i_clk), .i_srst(i_srst), .i_run_control(i_run_control),
  .i_timer_counter_select(i_timer_counter_select), .i_capture_reload_select(i_capture_reload_select),
  .i_external_trigger_enable(i_external_trigger_enable), .i_prescale_select(i_prescale_select),
  .i_clock_output_enable(i_clock_output_enable), .i_up_down_enable(i_up_down_enable),
  .i_global_irq_enable(i_global_irq_enable), .i_timer_irq_enable(i_timer_irq_enable),
  .i_count_high_byte_wr(i_count_high_byte_wr), .i_count_low_byte_wr(i_count_low_byte_wr),
  .i_flags_wr(i_flags_wr), .o_count_input_pin_pullup(o_count_input_pin_pullup),
  .o_count_high_byte(o_count_high_byte), .o_count_low_byte(o_count_low_byte),
  .o_capture_reload_high_byte(o_capture_reload_high_byte),
  .o_capture_reload_low_byte(o_capture_reload_low_byte), .o_overflow_flag(o_overflow_flag),
  .o_external_event_flag(o_external_event_flag), .o_timer_irq(o_timer_irq));

//--- tb/ttc_pin_drv.sv
module ttc_pin_drv (
  // Clock
  input wire logic i_clk,
  // Requests
  input wire logic i_cnt_req,
  input wire logic i_trg_req,
  input wire logic i_trg_lvl,
  // Pins
  output logic o_cnt_pin,
  output logic o_trg_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_q = 3'h0;
  logic [2:0] trg_q = 3'h0;
  // Low pulses last four cycles so the synchroniser cannot miss them
  always @(posedge i_clk) begin
    cnt_q <= i_cnt_req ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
    trg_q <= i_trg_req ? 3'h4 : trg_q - {2'h0, trg_q != 3'h0};
  end
  // Idle high, as the pull-up holds it
  assign o_cnt_pin = cnt_q == 3'h0;
  assign o_trg_pin = i_trg_lvl && trg_q == 3'h0;
endmodule // ttc_pin_drv

//--- tb/tb_ttc_timer.sv
module tb_ttc_timer;
  timeunit 1ns;
  timeprecision 100ps;
  import ttc_pkg::*;
  // ------------------------------------------------------------
  // Design and pin model
  // ------------------------------------------------------------
  logic i_clk = 1'b0, i_srst = 1'b1, i_run_control = 1'b0, i_timer_counter_select = 1'b0;
  logic i_capture_reload_select = 1'b0, i_external_trigger_enable = 1'b0, i_prescale_select = 1'b0;
  logic i_clock_output_enable = 1'b0, i_up_down_enable = 1'b0, i_global_irq_enable = 1'b1;
  logic i_timer_irq_enable = 1'b1, i_count_high_byte_wr = 1'b0, i_count_low_byte_wr = 1'b0;
  logic i_capture_reload_high_byte_wr = 1'b0, i_capture_reload_low_byte_wr = 1'b0, i_flags_wr = 1'b0;
  logic i_overflow_flag_wdata = 1'b0, i_external_event_flag_wdata = 1'b0;
  logic [BYTE_W-1:0] i_wdata = 8'h00;
  logic [BYTE_W-1:0] o_count_high_byte, o_count_low_byte, o_capture_reload_high_byte, o_capture_reload_low_byte;
  logic o_count_input_pin_o, o_count_input_pin_oe, o_count_input_pin_pullup;
  logic o_overflow_flag, o_external_event_flag, o_timer_irq;
  logic cnt_req = 1'b0, trg_req = 1'b0, trg_lvl = 1'b1, msel = 1'b0;
  wire i_count_input_pin, i_trigger_pin;
  int bad_count = 0, n_tests = 0;
  wire [15:0] cnt = {o_count_high_byte, o_count_low_byte};
  wire [15:0] rl = {o_capture_reload_high_byte, o_capture_reload_low_byte};
  wire [15:0] mon = msel ? {15'h0000, o_count_input_pin_o} : cnt;
  ttc_timer u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_run_control(i_run_control),
    .i_timer_counter_select(i_timer_counter_select), .i_capture_reload_select(i_capture_reload_select),
    .i_external_trigger_enable(i_external_trigger_enable), .i_prescale_select(i_prescale_select),
    .i_clock_output_enable(i_clock_output_enable), .i_up_down_enable(i_up_down_enable),
    .i_global_irq_enable(i_global_irq_enable), .i_timer_irq_enable(i_timer_irq_enable), .i_wdata(i_wdata),
    .i_count_high_byte_wr(i_count_high_byte_wr), .i_count_low_byte_wr(i_count_low_byte_wr),
    .i_capture_reload_high_byte_wr(i_capture_reload_high_byte_wr),
    .i_capture_reload_low_byte_wr(i_capture_reload_low_byte_wr), .i_flags_wr(i_flags_wr),
    .i_overflow_flag_wdata(i_overflow_flag_wdata), .i_external_event_flag_wdata(i_external_event_flag_wdata),
    .i_count_input_pin(i_count_input_pin), .i_trigger_pin(i_trigger_pin),
    .o_count_input_pin_o(o_count_input_pin_o), .o_count_input_pin_oe(o_count_input_pin_oe),
    .o_count_input_pin_pullup(o_count_input_pin_pullup), .o_count_high_byte(o_count_high_byte),
    .o_count_low_byte(o_count_low_byte), .o_capture_reload_high_byte(o_capture_reload_high_byte),
    .o_capture_reload_low_byte(o_capture_reload_low_byte), .o_overflow_flag(o_overflow_flag),
    .o_external_event_flag(o_external_event_flag), .o_timer_irq(o_timer_irq));
  ttc_pin_drv u_pins (.i_clk(i_clk), .i_cnt_req(cnt_req), .i_trg_req(trg_req), .i_trg_lvl(trg_lvl),
    .o_cnt_pin(i_count_input_pin), .o_trg_pin(i_trigger_pin));
  always #2.5 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Order: run, select, capture, trigger, prescale, clock-out, up/down
  task automatic mode(input logic [6:0] m);
    {i_run_control, i_timer_counter_select, i_capture_reload_select, i_external_trigger_enable,
      i_prescale_select, i_clock_output_enable, i_up_down_enable} = m;
  endtask
  // Ends on an idle cycle so strobes are never set and cleared in one step
  task automatic w16(input logic r, input logic [15:0] v);
    {i_capture_reload_high_byte_wr, i_count_high_byte_wr, i_wdata} = {r, !r, v[15:8]};
    @(negedge i_clk);
    {i_capture_reload_high_byte_wr, i_count_high_byte_wr, i_capture_reload_low_byte_wr, i_count_low_byte_wr,
      i_wdata} = {2'h0, r, !r, v[7:0]};
    @(negedge i_clk);
    {i_capture_reload_low_byte_wr, i_count_low_byte_wr} = 2'h0;
    @(negedge i_clk);
  endtask
  task automatic fl(input logic o, input logic e);
    {i_flags_wr, i_overflow_flag_wdata, i_external_event_flag_wdata} = {1'b1, o, e};
    @(negedge i_clk);
    i_flags_wr = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic pulse(input logic t);
    {trg_req, cnt_req} = {t, !t};
    @(negedge i_clk);
    {trg_req, cnt_req} = 2'h0;
    repeat (10) @(negedge i_clk);
  endtask
  task automatic gap(output int n);
    logic [15:0] v;
    v = mon;
    n = 0;
    while (mon === v && n < 100) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task automatic t_reload();
    w16(1'b1, 16'hFFF0);
    w16(1'b0, 16'hFFFF);
    mode(7'h44);
    @(negedge i_clk);
    chk("reload", 16'hFFF0, cnt);
    @(negedge i_clk);
    mode(7'h00);
    chk("ovf irq", 16'h0003, {o_overflow_flag, o_timer_irq});
    fl(1'b0, 1'b0);
    chk("cleared", 16'h0000, {o_overflow_flag, o_timer_irq});
    fl(1'b0, 1'b1);
    chk("sw evt irq", 16'h0003, {o_external_event_flag, o_timer_irq});
    i_global_irq_enable = 1'b0;
    @(negedge i_clk);
    chk("gated", 16'h0000, o_timer_irq);
    i_global_irq_enable = 1'b1;
    fl(1'b0, 1'b0);
  endtask
  task automatic t_presc();
    int n;
    w16(1'b0, 16'h0000);
    mode(7'h50);
    gap(n);
    gap(n);
    chk("step gap", 16'h000C, 16'(n));
    mode(7'h00);
    gap(n);
    chk("halted", 16'h0064, 16'(n));
    w16(1'b0, 16'hFFFE);
    mode(7'h54);
    repeat (2) @(negedge i_clk);
    mode(7'h00);
    chk("capture wrap", 16'h0000, cnt);
    chk("wrap flag irq", 16'h0003, {o_overflow_flag, o_timer_irq});
    fl(1'b0, 1'b0);
  endtask
  task automatic t_trig();
    for (int i = 0; i < 2; i++) begin
      mode(i ? 7'h08 : 7'h18);
      w16(1'b0, i ? 16'h0000 : 16'h1234);
      pulse(1'b1);
      chk("captured", 16'h1234, rl);
      chk("count", 16'h1234, cnt);
      chk("event", 16'h0001, o_external_event_flag);
      fl(1'b0, 1'b0);
    end
  endtask
  task automatic t_updown();
    int n;
    // Trigger enable off first, or the falling direction pin would reload the count
    mode(7'h00);
    w16(1'b1, 16'h0010);
    w16(1'b0, 16'h0011);
    trg_lvl = 1'b0;
    repeat (5) @(negedge i_clk);
    mode(7'h45);
    repeat (2) @(negedge i_clk);
    mode(7'h41);
    chk("underflow", 16'hFFFF, cnt);
    @(negedge i_clk);
    chk("wrap flags", 16'h0003, {o_overflow_flag, o_external_event_flag});
    fl(1'b0, 1'b1);
    chk("evt no irq", 16'h0002, {o_external_event_flag, o_timer_irq});
    trg_lvl = 1'b1;
    mode(7'h45);
    n = 0;
    while (o_overflow_flag !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    mode(7'h00);
    chk("up wrap", 16'h0002, {o_overflow_flag, o_external_event_flag});
    fl(1'b0, 1'b0);
  endtask
  task automatic t_count();
    w16(1'b0, 16'h0000);
    mode(7'h64);
    repeat (3) pulse(1'b0);
    chk("pin edges", 16'h0003, cnt);
    chk("pull-up", 16'h0001, o_count_input_pin_pullup);
    mode(7'h00);
  endtask
  task automatic t_clk();
    int n;
    msel = 1'b1;
    w16(1'b1, 16'hFFFC);
    w16(1'b0, 16'hFFF0);
    mode(7'h42);
    gap(n);
    repeat (2) begin
      gap(n);
      chk("half period", 16'h0008, 16'(n));
    end
    chk("drive", 16'h0001, o_count_input_pin_oe);
    chk("no flag", 16'h0000, o_overflow_flag);
    mode(7'h00);
    msel = 1'b0;
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_srst = 1'b0;
    @(negedge i_clk);
    chk("reset", 16'h0000, cnt | rl);
    t_reload();
    t_presc();
    t_trig();
    t_updown();
    t_count();
    t_clk();
    give_verdict();
  end
  // The tests need about 320 cycles
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule // tb_ttc_timer
